// ===== logic/guc_pkg.sv
// Shared constants and carrier types for the gated up/down pulse counter.
// Assumes a single 125 MHz system clock and a 32-bit classic Wishbone register bus.
package guc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets.
   localparam logic [7:0]  GUC_OFS_CTRL    = 8'h00;
   localparam logic [7:0]  GUC_OFS_RELOAD  = 8'h04;
   localparam logic [7:0]  GUC_OFS_END     = 8'h08;
   localparam logic [7:0]  GUC_OFS_COUNT   = 8'h0C;
   localparam logic [7:0]  GUC_OFS_LATCH   = 8'h10;
   localparam logic [7:0]  GUC_OFS_STATUS  = 8'h14;

   ////////////////////////////////////////////////////////////////////////////
   // Control register field positions.
   localparam int          GUC_CTL_SWGATE  = 0;
   localparam int          GUC_CTL_HWEN    = 1;
   localparam int          GUC_CTL_STOP    = 2;
   localparam int          GUC_CTL_MODE_LO = 3;
   localparam int          GUC_CTL_DIR_LO  = 5;
   localparam int          GUC_CTL_IRQEN   = 7;
   localparam int          GUC_CTL_WIDTH   = 8;

   // Status register field positions.
   localparam int          GUC_STS_OVF     = 0;
   localparam int          GUC_STS_UNF     = 1;
   localparam int          GUC_STS_GATE    = 2;
   localparam int          GUC_STS_CLOSED  = 3;
   localparam int          GUC_STS_HWOPEN  = 4;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values and count limits.
   localparam logic [7:0]  GUC_CTRL_RST    = 8'h00;
   localparam logic [31:0] GUC_RELOAD_RST  = 32'h0000_0000;
   localparam logic [31:0] GUC_END_RST     = 32'h0000_0000;
   localparam logic [31:0] GUC_COUNT_RST   = 32'h0000_0000;
   localparam logic [31:0] GUC_COUNT_MIN   = 32'h8000_0000;
   localparam logic [31:0] GUC_COUNT_MAX   = 32'h7FFF_FFFF;
   localparam logic [31:0] GUC_ONE         = 32'h0000_0001;

   ////////////////////////////////////////////////////////////////////////////
   // Operating modes and main counting directions.
   typedef enum logic [1:0] {
      GUC_MODE_CONT   = 2'h0,
      GUC_MODE_ONCE   = 2'h1,
      GUC_MODE_PERIOD = 2'h2
   } guc_mode_t;

   typedef enum logic [1:0] {
      GUC_DIR_NONE = 2'h0,
      GUC_DIR_FWD  = 2'h1,
      GUC_DIR_BWD  = 2'h2
   } guc_dir_t;

   ////////////////////////////////////////////////////////////////////////////
   // Pin group carried through the synchroniser.
   typedef struct packed {
      logic latch;
      logic hardware_gate;
      logic count_down;
      logic count_up;
   } guc_pins_t;

   typedef struct packed {
      logic [3:0] stage1;
      logic [3:0] stage2;
      logic [3:0] stage3;
   } guc_sync_state_t;

endpackage

// ===== logic/guc_sync.sv
// Three-flop synchroniser with edge detection for the counter's pin inputs.
// Assumes asynchronous pins; only the second stage and later feed logic.
`timescale 1ns/1ps
module guc_sync
   import guc_pkg::*;
(
   input  wire logic      clk_i,
   input  wire logic      rst_i,
   input  wire guc_pins_t pins_i,
   output guc_pins_t      level_o,
   output guc_pins_t      rise_o,
   output guc_pins_t      fall_o
);

   guc_sync_state_t st;
   guc_sync_state_t next_st;
   logic [3:0]      rise_v;
   logic [3:0]      fall_v;

   ////////////////////////////////////////////////////////////////////////////
   // Shift the pins through three stages.
   always_comb begin
      next_st        = st;
      next_st.stage1 = pins_i;
      next_st.stage2 = st.stage1;
      next_st.stage3 = st.stage2;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Edges are taken between the second and third stages.
   for (genvar i = 0; i < 4; i++) begin : g_edge
      assign rise_v[i] = st.stage2[i] & ~st.stage3[i];
      assign fall_v[i] = ~st.stage2[i] & st.stage3[i];
   end

   assign level_o = st.stage2;
   assign rise_o  = rise_v;
   assign fall_o  = fall_v;

endmodule

// ===== logic/guc_counter.sv
// Gated 32-bit signed up/down pulse counter with latch and sticky flags.
// Assumes one 125 MHz clock, a classic Wishbone master, and encoder pins on inputs.
//
// Notes on behaviour
// - With no main direction the count spans the full signed 32-bit range.
// - Continuous counting begins from the reload value when counting starts.
// - Continuous mode: up pulse at upper limit wraps to lower limit.
// - Continuous mode: down pulse at lower limit wraps to upper limit.
// - Overflow and underflow set sticky flags, cleared only by software clear.
// - With interrupt enabled, every overflow or underflow raises the process interrupt.
// - Once mode, no direction: wrap at a limit, close gate, set flag.
// - After automatic close in once mode, no counting until gate reopens.
// - Once forward: at end minus one, next up pulse reloads and closes gate.
// - Once backward: at end plus one, next down pulse reloads and closes gate.
// - Once mode with direction restarts from reload when the gate reopens after an automatic close.
// - Periodic, no direction: wrap at a limit and keep counting.
// - Periodic forward: at end minus one, next up pulse reloads and continues.
// - Periodic backward: at end plus one, next down pulse reloads; may exceed top.
// - Counting only while internal gate, from hardware and software gates, is open.
// - Hardware gate opens on rising input edge, closes on falling edge.
// - Cancel gate function restarts from reload value when the gate reopens.
// - Stop gate function resumes from the last count when the gate reopens.
// - Hardware gate disabled: software gate rise reloads under cancel, resumes under stop.
// - Hardware gate enabled: only its rising edge restarts; software rise continues.
// - Rising latch input copies the current count into the readable latch register.
// - Main direction is none, forward or backward; none gives full range.
`timescale 1ns/1ps
module guc_counter
   import guc_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        count_up_i,
   input  wire logic        count_down_i,
   input  wire logic        hardware_gate_i,
   input  wire logic        latch_i,
   output logic             process_irq_o
);

   typedef struct packed {
      logic [7:0]  ctrl;
      logic [31:0] reload;
      logic [31:0] end_val;
      logic [31:0] count;
      logic [31:0] latched_count_out;
      logic        overflow_flag;
      logic        underflow_flag;
      logic        auto_closed;
      logic        fresh;
      logic        hw_open;
      logic        sw_prev;
      logic        irq;
      logic        ack;
      logic [31:0] dat;
   } guc_state_t;

   guc_state_t st;
   guc_state_t next_st;
   guc_pins_t  pins;
   guc_pins_t  rise;
   guc_pins_t  fall;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisation and edge detection.
   assign pins = '{latch: latch_i, hardware_gate: hardware_gate_i,
                   count_down: count_down_i, count_up: count_up_i};

   guc_sync u_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .pins_i  (pins),
      .level_o (),
      .rise_o  (rise),
      .fall_o  (fall)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Control decode and gate logic.
   logic        software_gate;
   logic        hw_en;
   logic        stop_fn;
   logic        irq_en;
   guc_mode_t   mode;
   guc_dir_t    dir;
   guc_dir_t    eff_dir;
   logic        sw_rise;
   logic        restart;
   logic        gate_open;
   logic        step_up;
   logic        step_dn;
   logic        ofl_ev;
   logic        ufl_ev;
   logic        flag_clear_request;
   logic        bus_req;
   logic        bus_wr;
   logic [31:0] rd_val;
   logic [31:0] end_m1;
   logic [31:0] end_p1;
   logic [31:0] ctrl_wr;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[8*b +: 8] = dat[8*b +: 8];
         end
      end
      return res;
   endfunction

   assign ctrl_wr       = merge({24'h000000, st.ctrl}, wb_dat_i, wb_sel_i);
   assign software_gate = st.ctrl[GUC_CTL_SWGATE];
   assign hw_en         = st.ctrl[GUC_CTL_HWEN];
   assign stop_fn       = st.ctrl[GUC_CTL_STOP];
   assign irq_en        = st.ctrl[GUC_CTL_IRQEN];
   assign mode          = guc_mode_t'(st.ctrl[GUC_CTL_MODE_LO +: 2]);
   assign dir           = guc_dir_t'(st.ctrl[GUC_CTL_DIR_LO +: 2]);
   assign eff_dir       = (mode == GUC_MODE_CONT) ? GUC_DIR_NONE : dir;
   assign sw_rise       = software_gate & ~st.sw_prev;
   assign restart       = hw_en ? (rise.hardware_gate & software_gate) : sw_rise;
   assign gate_open     = software_gate & (~hw_en | st.hw_open) & ~st.auto_closed;
   assign step_up       = gate_open & ~restart & rise.count_up & ~rise.count_down;
   assign step_dn       = gate_open & ~restart & rise.count_down & ~rise.count_up;
   assign end_m1        = st.end_val - GUC_ONE;
   assign end_p1        = st.end_val + GUC_ONE;
   assign bus_req       = wb_cyc_i & wb_stb_i & ~st.ack;
   assign bus_wr        = bus_req & wb_we_i;
   assign flag_clear_request = bus_wr && (wb_adr_i == GUC_OFS_STATUS);

   ////////////////////////////////////////////////////////////////////////////
   // Read multiplexer.
   always_comb begin
      rd_val = '0;
      if (wb_adr_i == GUC_OFS_CTRL) begin
         rd_val[GUC_CTL_WIDTH-1:0] = st.ctrl;
      end else if (wb_adr_i == GUC_OFS_RELOAD) begin
         rd_val = st.reload;
      end else if (wb_adr_i == GUC_OFS_END) begin
         rd_val = st.end_val;
      end else if (wb_adr_i == GUC_OFS_COUNT) begin
         rd_val = st.count;
      end else if (wb_adr_i == GUC_OFS_LATCH) begin
         rd_val = st.latched_count_out;
      end else if (wb_adr_i == GUC_OFS_STATUS) begin
         rd_val[GUC_STS_OVF]    = st.overflow_flag;
         rd_val[GUC_STS_UNF]    = st.underflow_flag;
         rd_val[GUC_STS_GATE]   = gate_open;
         rd_val[GUC_STS_CLOSED] = st.auto_closed;
         rd_val[GUC_STS_HWOPEN] = st.hw_open;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic.
   always_comb begin
      next_st         = st;
      ofl_ev          = 1'b0;
      ufl_ev          = 1'b0;
      next_st.sw_prev = software_gate;

      if (rise.hardware_gate) begin
         next_st.hw_open = 1'b1;
      end else if (fall.hardware_gate) begin
         next_st.hw_open = 1'b0;
      end

      if (restart) begin
         if (st.fresh || !stop_fn || (st.auto_closed && eff_dir != GUC_DIR_NONE)) begin
            next_st.count = st.reload;
         end
         next_st.auto_closed = 1'b0;
         next_st.fresh       = 1'b0;
      end else if (step_up) begin
         if (eff_dir == GUC_DIR_FWD && st.count == end_m1) begin
            next_st.count = st.reload;
            if (mode == GUC_MODE_ONCE) begin
               next_st.auto_closed = 1'b1;
            end
         end else if (st.count == GUC_COUNT_MAX) begin
            next_st.count = GUC_COUNT_MIN;
            ofl_ev        = 1'b1;
            if (mode == GUC_MODE_ONCE && eff_dir == GUC_DIR_NONE) begin
               next_st.auto_closed = 1'b1;
            end
         end else begin
            next_st.count = st.count + GUC_ONE;
         end
      end else if (step_dn) begin
         if (eff_dir == GUC_DIR_BWD && st.count == end_p1) begin
            next_st.count = st.reload;
            if (mode == GUC_MODE_ONCE) begin
               next_st.auto_closed = 1'b1;
            end
         end else if (st.count == GUC_COUNT_MIN) begin
            next_st.count = GUC_COUNT_MAX;
            ufl_ev        = 1'b1;
            if (mode == GUC_MODE_ONCE && eff_dir == GUC_DIR_NONE) begin
               next_st.auto_closed = 1'b1;
            end
         end else begin
            next_st.count = st.count - GUC_ONE;
         end
      end

      next_st.overflow_flag  = (st.overflow_flag & ~flag_clear_request) | ofl_ev;
      next_st.underflow_flag = (st.underflow_flag & ~flag_clear_request) | ufl_ev;
      next_st.irq            = irq_en & (ofl_ev | ufl_ev);

      if (rise.latch) begin
         next_st.latched_count_out = st.count;
      end

      next_st.ack = bus_req;
      next_st.dat = bus_req ? rd_val : st.dat;
      if (bus_wr) begin
         if (wb_adr_i == GUC_OFS_CTRL) begin
            next_st.ctrl = ctrl_wr[GUC_CTL_WIDTH-1:0];
         end else if (wb_adr_i == GUC_OFS_RELOAD) begin
            next_st.reload = merge(st.reload, wb_dat_i, wb_sel_i);
         end else if (wb_adr_i == GUC_OFS_END) begin
            next_st.end_val = merge(st.end_val, wb_dat_i, wb_sel_i);
         end else if (wb_adr_i == GUC_OFS_COUNT) begin
            next_st.count = merge(st.count, wb_dat_i, wb_sel_i);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st                   <= '0;
         st.ctrl              <= GUC_CTRL_RST;
         st.reload            <= GUC_RELOAD_RST;
         st.end_val           <= GUC_END_RST;
         st.count             <= GUC_COUNT_RST;
         st.latched_count_out <= GUC_COUNT_RST;
         st.fresh             <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign wb_dat_o      = st.dat;
   assign wb_ack_o      = st.ack;
   assign process_irq_o = st.irq;

   ////////////////////////////////////////////////////////////////////////////
   // Checks on the counter behaviour.
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   wrap_up_max_a: assert property (step_up && eff_dir == GUC_DIR_NONE && st.count == GUC_COUNT_MAX
      |=> st.count == GUC_COUNT_MIN && st.overflow_flag)
      else $error("up pulse at upper limit did not wrap");

   wrap_dn_min_a: assert property (step_dn && eff_dir == GUC_DIR_NONE && st.count == GUC_COUNT_MIN
      |=> st.count == GUC_COUNT_MAX && st.underflow_flag)
      else $error("down pulse at lower limit did not wrap");

   flag_sticky_a: assert property (st.overflow_flag && !flag_clear_request |=> st.overflow_flag)
      else $error("overflow flag dropped without a clear");

   clear_race_a: assert property (flag_clear_request && ufl_ev |=> st.underflow_flag)
      else $error("underflow event lost against a clear");

   irq_pulse_a: assert property (irq_en && (ofl_ev || ufl_ev) |=> process_irq_o ##1 (!process_irq_o
      || $past(ofl_ev || ufl_ev)))
      else $error("process interrupt not pulsed on limit event");

   once_close_a: assert property (mode == GUC_MODE_ONCE && (ofl_ev || ufl_ev) && eff_dir == GUC_DIR_NONE
      |=> st.auto_closed && !gate_open)
      else $error("count once did not close the gate");

   closed_hold_a: assert property (st.auto_closed && !restart && !bus_wr |=> $stable(st.count))
      else $error("count changed with the gate closed automatically");

   fwd_end_a: assert property (step_up && eff_dir == GUC_DIR_FWD && st.count == end_m1
      |=> st.count == $past(st.reload) && (st.auto_closed == (mode == GUC_MODE_ONCE)))
      else $error("forward end value did not reload");

   bwd_end_a: assert property (step_dn && eff_dir == GUC_DIR_BWD && st.count == end_p1
      |=> st.count == $past(st.reload) && (st.auto_closed == (mode == GUC_MODE_ONCE)))
      else $error("backward end value did not reload");

   cancel_load_a: assert property (restart && !stop_fn && !bus_wr |=> st.count == $past(st.reload))
      else $error("cancel restart did not load the reload value");

   hw_open_a: assert property (rise.hardware_gate |=> st.hw_open)
      else $error("hardware gate did not open on rising edge");

   latch_copy_a: assert property (rise.latch |=> st.latched_count_out == $past(st.count))
      else $error("latch edge did not capture the count");

   bus_ack_a: assert property (bus_req |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus access not answered in one cycle");

   stop_hold_a: assert property (restart && stop_fn && !st.fresh && !st.auto_closed && !bus_wr
      |=> $stable(st.count))
      else $error("stop restart did not keep the count");

   gate_shut_a: assert property (!gate_open && !restart && !bus_wr |=> $stable(st.count))
      else $error("count changed with the internal gate closed");

   both_edges_a: assert property (rise.count_up && rise.count_down && !restart && !bus_wr
      |=> $stable(st.count))
      else $error("coinciding up and down edges moved the count");

   once_restart_a: assert property (restart && st.auto_closed && eff_dir != GUC_DIR_NONE && !bus_wr
      |=> st.count == $past(st.reload) && !st.auto_closed)
      else $error("once restart did not load the reload value");

   period_reload_c: cover property (step_up && mode == GUC_MODE_PERIOD && eff_dir == GUC_DIR_FWD
      && st.count == end_m1);
   wrap_seen_c: cover property (step_up && st.count == GUC_COUNT_MAX);
   once_done_c: cover property (mode == GUC_MODE_ONCE && !st.auto_closed ##1 st.auto_closed);
   latch_seen_c: cover property (rise.latch && gate_open);
   clear_race_c: cover property (flag_clear_request && (ofl_ev || ufl_ev));

endmodule

// ===== test/guc_encoder_model.sv
// Behavioural encoder and pin driver that stands in front of the counter's pins.
// Assumes the bench calls its tasks one at a time from a single process.
`timescale 1ns/1ps
module guc_encoder_model
   import guc_pkg::*;
(
   input  wire logic clk_i,
   output guc_pins_t pins_o
);
   initial begin
      pins_o = '0;
   end

   ////////////////////////////////////////////////////////////////
   // Pulses the pins in mask, two clocks high and four low.
   task automatic pulse(input logic [3:0] mask);
      @(posedge clk_i);
      pins_o <= pins_o | mask;
      repeat (2) @(posedge clk_i);
      pins_o <= pins_o & ~mask;
      repeat (4) @(posedge clk_i);
   endtask

   // Moves the hardware gate pin and lets the edge settle.
   task automatic set_gate(input logic v);
      @(posedge clk_i);
      pins_o.hardware_gate <= v;
      repeat (5) @(posedge clk_i);
   endtask
endmodule

// ===== test/guc_counter_tb.sv
// Self-checking bench for the gated up/down pulse counter.
// Assumes the encoder model drives the pins and this bench is the bus master.
`timescale 1ns/1ps
module guc_counter_tb;
   import guc_pkg::*;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc;
   logic        stb;
   logic        we;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat;
   logic [31:0] rdat;
   logic        ack;
   logic        irq;
   guc_pins_t   pins;
   int          miscompares = 0;
   int          checks = 0;
   int          irqs = 0;
   int          cycles = 0;
   int          m;
   int          d;
   logic [31:0] x;
   logic [31:0] rl;
   logic [31:0] e;
   logic [7:0]  offs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20};

   always #4 clk_i = ~clk_i;

   guc_encoder_model enc (.clk_i(clk_i), .pins_o(pins));

   guc_counter dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .count_up_i(pins.count_up), .count_down_i(pins.count_down),
      .hardware_gate_i(pins.hardware_gate), .latch_i(pins.latch), .process_irq_o(irq)
   );

   always @(posedge clk_i) begin
      if (irq === 1'b1) begin
         irqs <= irqs + 1;
      end
   end

   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares = miscompares + 1;
         summarize();
      end
   end

   ////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] ex, input logic [31:0] got);
      checks = checks + 1;
      if (got !== ex) begin
         miscompares = miscompares + 1;
         $display("mismatch %s expected %h seen %h", what, ex, got);
      end
   endtask

   // One classic Wishbone cycle, held until ack is sampled high.
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dv, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hF;
      wdat <= dv;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      chk("bus ack", 32'h1, {31'h0, ack});
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] dv);
      logic [31:0] q;
      wb(1'b1, a, dv, q);
   endtask

   task automatic rdm(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] ex, input string what);
      logic [31:0] q;
      wb(1'b0, a, 32'h0000_0000, q);
      chk(what, ex, q & mk);
   endtask

   function automatic logic [31:0] ctl(input logic sw, hw, st, input logic [1:0] md, dr, input logic ie);
      logic [31:0] v;
      v = '0;
      v[GUC_CTL_SWGATE] = sw;
      v[GUC_CTL_HWEN] = hw;
      v[GUC_CTL_STOP] = st;
      v[GUC_CTL_MODE_LO+:2] = md;
      v[GUC_CTL_DIR_LO+:2] = dr;
      v[GUC_CTL_IRQEN] = ie;
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////
   initial begin
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      adr <= 8'h00;
      sel <= 4'h0;
      wdat <= 32'h0000_0000;
      void'($urandom(32'hA3EF1868));
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (offs[i]) rdm(offs[i], '1, '0, "reset value");
      rl = $urandom;
      wr(GUC_OFS_RELOAD, rl);
      wr(GUC_OFS_CTRL, ctl(1, 0, 0, GUC_MODE_CONT, GUC_DIR_NONE, 1));
      rdm(GUC_OFS_COUNT, '1, rl, "start count");
      x = rl;
      repeat (10) begin
         d = $urandom_range(1, 0);
         enc.pulse(d ? 4'h2 : 4'h1);
         x = d ? x - 1 : x + 1;
      end
      rdm(GUC_OFS_COUNT, '1, x, "random count");
      wr(GUC_OFS_CTRL, ctl(0, 0, 0, GUC_MODE_CONT, GUC_DIR_NONE, 1));
      enc.pulse(4'h1);
      rdm(GUC_OFS_COUNT, '1, x, "gated count");
      for (int st = 0; st < 2; st++) begin
         wr(GUC_OFS_CTRL, ctl(1, 0, 1'(st), GUC_MODE_CONT, GUC_DIR_NONE, 1));
         x = st ? x : rl;
         rdm(GUC_OFS_COUNT, '1, x, "restart count");
         enc.pulse(4'h1);
         x = x + 1;
         wr(GUC_OFS_CTRL, ctl(0, 0, 1'(st), GUC_MODE_CONT, GUC_DIR_NONE, 1));
      end
      for (m = 0; m < 3; m++) begin
         for (d = 0; d < 2; d++) begin
            wr(GUC_OFS_CTRL, ctl(0, 0, 1, 2'(m), GUC_DIR_NONE, 1'(m != 1)));
            wr(GUC_OFS_CTRL, ctl(1, 0, 1, 2'(m), GUC_DIR_NONE, 1'(m != 1)));
            wr(GUC_OFS_STATUS, '0);
            wr(GUC_OFS_COUNT, d ? GUC_COUNT_MIN : GUC_COUNT_MAX);
            x = 32'(irqs);
            enc.pulse(d ? 4'h2 : 4'h1);
            rdm(GUC_OFS_COUNT, '1, d ? GUC_COUNT_MAX : GUC_COUNT_MIN, "wrap count");
            rdm(GUC_OFS_STATUS, 32'hB, {28'h0, m == 1, 1'b0, 1'(d), d == 0}, "wrap flags");
            chk("irq pulses", x + 32'(m != 1), 32'(irqs));
            enc.pulse(d ? 4'h2 : 4'h1);
            x = m == 1 ? 32'h0 : (d ? -32'h1 : 32'h1);
            rdm(GUC_OFS_COUNT, '1, (d ? GUC_COUNT_MAX : GUC_COUNT_MIN) + x, "after wrap");
            wr(GUC_OFS_STATUS, '0);
            rdm(GUC_OFS_STATUS, 32'h3, '0, "cleared flags");
         end
      end
      for (m = 1; m < 3; m++) begin
         for (d = 1; d < 3; d++) begin
            rl = $urandom_range(5000, 100);
            e = d == 1 ? rl + 3 : rl - 3;
            wr(GUC_OFS_RELOAD, rl);
            wr(GUC_OFS_END, e);
            wr(GUC_OFS_CTRL, ctl(0, 0, 0, 2'(m), 2'(d), 0));
            wr(GUC_OFS_CTRL, ctl(1, 0, 0, 2'(m), 2'(d), 0));
            rdm(GUC_OFS_COUNT, '1, rl, "dir start");
            repeat (2) enc.pulse(d == 1 ? 4'h1 : 4'h2);
            rdm(GUC_OFS_COUNT, '1, d == 1 ? e - 1 : e + 1, "near end");
            repeat (2) enc.pulse(d == 1 ? 4'h1 : 4'h2);
            x = m == 1 ? rl : (d == 1 ? rl + 1 : rl - 1);
            rdm(GUC_OFS_COUNT, '1, x, "past end");
            rdm(GUC_OFS_STATUS, 32'hB, {28'h0, m == 1, 3'h0}, "end flags");
            if (m == 1) begin
               wr(GUC_OFS_CTRL, ctl(0, 0, 1, 2'(m), 2'(d), 0));
               wr(GUC_OFS_COUNT, rl + 1);
               wr(GUC_OFS_CTRL, ctl(1, 0, 1, 2'(m), 2'(d), 0));
               rdm(GUC_OFS_COUNT, '1, rl, "once restart");
            end
         end
      end
      wr(GUC_OFS_CTRL, ctl(0, 1, 0, GUC_MODE_CONT, GUC_DIR_NONE, 0));
      wr(GUC_OFS_COUNT, 32'h0000_0100);
      wr(GUC_OFS_CTRL, ctl(1, 1, 0, GUC_MODE_CONT, GUC_DIR_NONE, 0));
      enc.pulse(4'h1);
      rdm(GUC_OFS_COUNT, '1, 32'h0000_0100, "hw closed");
      enc.set_gate(1'b1);
      rdm(GUC_OFS_COUNT, '1, rl, "hw restart");
      rdm(GUC_OFS_STATUS, 32'h14, 32'h14, "hw open");
      enc.pulse(4'h1);
      wr(GUC_OFS_CTRL, ctl(0, 1, 0, GUC_MODE_CONT, GUC_DIR_NONE, 0));
      wr(GUC_OFS_CTRL, ctl(1, 1, 0, GUC_MODE_CONT, GUC_DIR_NONE, 0));
      rdm(GUC_OFS_COUNT, '1, rl + 1, "sw reopen");
      enc.set_gate(1'b0);
      enc.pulse(4'h1);
      rdm(GUC_OFS_COUNT, '1, rl + 1, "hw shut count");
      rdm(GUC_OFS_STATUS, 32'h14, '0, "hw shut");
      x = $urandom;
      wr(GUC_OFS_COUNT, x);
      enc.pulse(4'h8);
      rdm(GUC_OFS_LATCH, '1, x, "latch");
      summarize();
   end
endmodule
